// ==== pidreg_top.sv ====
// pid regulator: target and feedback select, pid, post-processing, loss supervision
// assumes analog, pulse and reference values come from logic on core_clk;
// digital input functions arrive from pins
//
// What this block does
// R1: modes 1,2 output drives frequency; modes 3,4 add it to the reference
// R2: modes 2,4 differentiate feedback only; modes 1,3 differentiate the error
// R3: regulation is active for mode selector values 1 through 4
// R4: target defaults to the selected frequency reference
// R5: analog input 2 function C supplies the target
// R6: serial source bit 1 set makes the serial target register the target
// R7: pulse input function 2 supplies the target
// R8: analog input 2 function B supplies the feedback
// R9: pulse input function 1 supplies the feedback
// R10: integral term clamped to the integral limit
// R11: pid sum clamped to the output limit
// R12: offset in 0.1 % steps added to the output
// R13: first-order low-pass filter on the output
// R14: polarity setting inverts the output sign
// R15: output multiplied by the output gain
// R16: negative output reverses when allowed, else clamped to zero
// R17: target changes ramped by the target ramp time
// R18: soft start input bypasses the target ramp during operation
// R19: derivative time zero disables the derivative term
// R20: loss select 1 raises alarm after loss time, drive keeps running
// R21: loss select 2 raises fault, fault contact and stops the drive
// R22: disable input bypasses regulation
// R23: reset input, reset command or stop clears the integral
// R24: hold input freezes the integral
// R25: mode 0 passes the frequency reference unchanged
`timescale 1ns/100ps
`default_nettype none
`include "pidreg_defs.svh"

module pidreg_top import pidreg_pkg::*; #(
  parameter int unsigned SAMPLE_CYCLES = `PIDREG_SAMPLE_CYC
) (
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  // settings
  input  wire pidreg_cfg_s        cfg,
  // digital input functions, asynchronous pins
  input  wire pidreg_di_s         di_pins,
  // drive values
  input  wire logic signed [15:0] analog_in2_terminal,
  input  wire logic signed [15:0] pulse_in,
  input  wire logic signed [15:0] freq_ref,
  input  wire logic               run,
  input  wire logic               reset_cmd,
  // serial register port
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  input  wire logic [15:0]        reg_addr,
  input  wire logic [15:0]        reg_wdata,
  output var  logic [15:0]        reg_rdata,
  // results
  output var  logic signed [15:0] freq_out,
  output var  logic               reverse_dir,
  output var  logic               pid_active,
  output var  logic               feedback_lost_alarm,
  output var  logic               fault_contact,
  output var  logic               stop_req
);

  function automatic pidreg_val_t ext16(input logic signed [15:0] x);
    ext16 = pidreg_val_t'(x);
  endfunction

  function automatic logic signed [37:0] wide(input pidreg_val_t x);
    wide = 38'(x);
  endfunction

  function automatic pidreg_val_t clamp_sym(input logic signed [37:0] x,
                                            input logic [15:0] lim);
    logic signed [37:0] l;
    l = $signed({22'h00_0000, lim});
    if (x > l) begin
      clamp_sym = pidreg_val_t'(l);
    end else if (x < -l) begin
      clamp_sym = pidreg_val_t'(-l);
    end else begin
      clamp_sym = pidreg_val_t'(x);
    end
  endfunction

  function automatic pidreg_val_t mul_shift(input pidreg_val_t a,
                                            input logic [15:0] k);
    logic signed [37:0] m;
    m = wide(a) * $signed({22'h00_0000, k});
    mul_shift = clamp_sym(m >>> `PIDREG_GAIN_SHIFT, `PIDREG_SAT);
  endfunction

  pidreg_di_s         di_meta;
  pidreg_di_s         di_sync;
  logic [15:0]        tick_cnt;
  logic               tick;
  logic [15:0]        reg_target;
  logic [15:0]        reg_srcsel;
  logic               regulating;
  logic               direct_mode;
  logic               d_on_fb;
  logic               int_clear;
  pidreg_val_t        tgt_sel;
  pidreg_val_t        fb_sel;
  pidreg_val_t        tgt_ramp;
  pidreg_val_t        err;
  pidreg_val_t        p_term;
  pidreg_val_t        i_step;
  pidreg_val_t        integ;
  pidreg_val_t        next_integ;
  pidreg_val_t        d_src;
  pidreg_val_t        d_prev;
  pidreg_val_t        d_term;
  pidreg_val_t        sum_lim;
  pidreg_val_t        offs;
  pidreg_val_t        filt;
  pidreg_val_t        next_filt;
  pidreg_val_t        pol;
  pidreg_val_t        gained;
  pidreg_val_t        g_lim;
  pidreg_val_t        next_out;
  logic               loss_low;
  logic               loss_hit;
  logic [15:0]        loss_cnt;
  pidreg_loss_e       lstate;
  pidreg_loss_e       next_lstate;

  // pin synchroniser
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      di_meta <= '0;
      di_sync <= '0;
    end else begin
      di_meta <= di_pins;
      di_sync <= di_meta;
    end
  end

  // sample period
  always_ff @(posedge core_clk) begin
    if (!rst_n || tick) begin
      tick_cnt <= 16'h0000;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
    end
  end
  assign tick = (tick_cnt == 16'(SAMPLE_CYCLES - 1));

  // serial registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_target <= `PIDREG_RST_TARGET;
      reg_srcsel <= `PIDREG_RST_SRCSEL;
    end else if (reg_wr) begin
      if (reg_addr == `PIDREG_REG_TARGET) begin
        reg_target <= reg_wdata;
      end else if (reg_addr == `PIDREG_REG_SRCSEL) begin
        reg_srcsel <= reg_wdata;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd && reg_addr == `PIDREG_REG_TARGET) begin
      reg_rdata <= reg_target;
    end else if (reg_rd && reg_addr == `PIDREG_REG_SRCSEL) begin
      reg_rdata <= reg_srcsel;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // mode decode
  always_comb begin
    // R3 closed loop on
    // R22 disable input
    regulating  = (cfg.pid_mode_select >= `PIDREG_MODE_1) &&
                  (cfg.pid_mode_select <= `PIDREG_MODE_4) && !di_sync.pid_disable;
    direct_mode = (cfg.pid_mode_select == `PIDREG_MODE_1) ||
                  (cfg.pid_mode_select == `PIDREG_MODE_2);
    d_on_fb     = (cfg.pid_mode_select == `PIDREG_MODE_2) ||
                  (cfg.pid_mode_select == `PIDREG_MODE_4);
    // R23 integral clear
    int_clear   = di_sync.int_reset || reset_cmd || (regulating && !run);
  end

  // target and feedback sources
  always_comb begin
    // R6 serial target
    if (reg_srcsel[`PIDREG_SRCSEL_TGT]) begin
      tgt_sel = ext16(reg_target);
    // R5 analog target
    end else if (cfg.analog_in2_function == `PIDREG_AIN_TGT) begin
      tgt_sel = ext16(analog_in2_terminal);
    // R7 pulse target
    end else if (cfg.pulse_input_function == `PIDREG_PULSE_TGT) begin
      tgt_sel = ext16(pulse_in);
    // R4 reference default
    end else begin
      tgt_sel = ext16(freq_ref);
    end
    // R8 analog feedback
    if (cfg.analog_in2_function == `PIDREG_AIN_FB) begin
      fb_sel = ext16(analog_in2_terminal);
    // R9 pulse feedback
    end else if (cfg.pulse_input_function == `PIDREG_PULSE_FB) begin
      fb_sel = ext16(pulse_in);
    end else begin
      fb_sel = '0;
    end
  end

  pidreg_ramp u_ramp (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .tick      (tick),
    .bypass    (di_sync.soft_start && run),
    .ramp_time (cfg.target_ramp_time),
    .target    (tgt_sel),
    .ramped    (tgt_ramp)
  );

  // pid terms
  always_comb begin
    err    = tgt_ramp - fb_sel;
    p_term = mul_shift(err, cfg.proportional_gain);
    i_step = '0;
    if (cfg.integral_time != 16'h0000) begin
      i_step = pidreg_val_t'(wide(p_term) / $signed({22'h00_0000, cfg.integral_time}));
    end
    // R10 integral limit
    next_integ = clamp_sym(wide(integ) + wide(i_step), cfg.integral_limit);
    // R2 derivative source
    d_src  = d_on_fb ? -fb_sel : err;
    // R19 derivative off
    d_term = (cfg.derivative_time == 16'h0000) ? '0 :
             mul_shift(d_src - d_prev, cfg.derivative_time);
  end

  // R23 integral clear
  // R24 integral hold
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      integ <= '0;
    end else if (tick) begin
      if (int_clear || !regulating || cfg.integral_time == 16'h0000) begin
        integ <= '0;
      end else if (!di_sync.int_hold) begin
        integ <= next_integ;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      d_prev <= '0;
    end else if (tick) begin
      d_prev <= d_src;
    end
  end

  // post-processing chain
  always_comb begin
    // R11 output limit
    sum_lim   = clamp_sym(wide(p_term) + wide(integ) + wide(d_term), cfg.output_limit);
    // R12 offset
    offs      = clamp_sym(wide(sum_lim) + wide(ext16(cfg.output_offset)) * `PIDREG_OFS_SCALE,
                          `PIDREG_SAT);
    // R13 low-pass filter
    next_filt = clamp_sym(((wide(offs) - wide(filt)) >>> cfg.output_filter_time) + wide(filt),
                          `PIDREG_SAT);
    // R14 polarity
    pol       = cfg.output_polarity ? -filt : filt;
    // R15 output gain
    gained    = mul_shift(pol, cfg.output_gain);
    // R16 reverse handling
    g_lim     = gained;
    if (gained < 0 && (cfg.reverse_prohibit || !cfg.negative_reverse_select)) begin
      g_lim = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n || !regulating) begin
      filt <= '0;
    end else if (tick) begin
      filt <= next_filt;
    end
  end

  // frequency output
  always_comb begin
    if (lstate == PIDREG_LS_FAULT) begin
      next_out = '0;
    // R25 bypass
    end else if (!regulating) begin
      next_out = ext16(freq_ref);
    // R1 direct drive
    end else if (direct_mode) begin
      next_out = clamp_sym(wide(g_lim), `PIDREG_OUT_MAX);
    end else begin
      next_out = clamp_sym(wide(ext16(freq_ref)) + wide(g_lim), `PIDREG_OUT_MAX);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      freq_out    <= 16'h0000;
      reverse_dir <= 1'b0;
      pid_active  <= 1'b0;
    end else if (tick) begin
      freq_out    <= 16'(next_out);
      reverse_dir <= next_out < 0;
      pid_active  <= regulating;
    end
  end

  // feedback loss supervision
  assign loss_low = regulating && (cfg.loss_detect_select != 2'h0) &&
                    (fb_sel < ext16(cfg.loss_detect_level));
  assign loss_hit = loss_low && (loss_cnt >= cfg.loss_detect_time);

  always_ff @(posedge core_clk) begin
    if (!rst_n || !loss_low) begin
      loss_cnt <= 16'h0000;
    end else if (tick && !loss_hit) begin
      loss_cnt <= loss_cnt + 16'h0001;
    end
  end

  always_comb begin
    next_lstate = lstate;
    case (lstate)
      PIDREG_LS_OK: begin
        // R20 alarm only
        // R21 fault stop
        if (loss_hit && cfg.loss_detect_select == `PIDREG_LOSS_FAULT) begin
          next_lstate = PIDREG_LS_FAULT;
        end else if (loss_hit && cfg.loss_detect_select == `PIDREG_LOSS_ALARM) begin
          next_lstate = PIDREG_LS_ALARM;
        end
      end
      PIDREG_LS_ALARM: begin
        if (!loss_low) begin
          next_lstate = PIDREG_LS_OK;
        end else if (cfg.loss_detect_select == `PIDREG_LOSS_FAULT) begin
          next_lstate = PIDREG_LS_FAULT;
        end
      end
      PIDREG_LS_FAULT: begin
        // fault held while loss persists, even under reset command
        if (reset_cmd && !loss_hit) begin
          next_lstate = PIDREG_LS_OK;
        end
      end
      default: begin
        next_lstate = PIDREG_LS_OK;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lstate <= PIDREG_LS_OK;
    end else begin
      lstate <= next_lstate;
    end
  end

  assign feedback_lost_alarm = (lstate != PIDREG_LS_OK);
  assign fault_contact       = (lstate == PIDREG_LS_FAULT);
  assign stop_req            = (lstate == PIDREG_LS_FAULT);

  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence fault_s;
    lstate == PIDREG_LS_FAULT;
  endsequence

  sequence alarm_run_s;
    feedback_lost_alarm && !stop_req;
  endsequence

  bypass_pass_a: // R25
    assert property (tick && !regulating && !fault_contact |=> freq_out == $past(freq_ref))
    else $error("bypass did not pass reference");

  integ_limit_a: // R10
    assert property (wide(integ) <= $signed({22'h00_0000, cfg.integral_limit}) &&
                     wide(integ) >= -$signed({22'h00_0000, cfg.integral_limit}))
    else $error("integral beyond limit");

  out_limit_a: // R11
    assert property (wide(sum_lim) <= $signed({22'h00_0000, cfg.output_limit}) &&
                     wide(sum_lim) >= -$signed({22'h00_0000, cfg.output_limit}))
    else $error("pid sum beyond output limit");

  int_clear_a: // R23
    assert property (tick && int_clear |=> integ == '0)
    else $error("integral not cleared");

  int_hold_a: // R24
    assert property (tick && di_sync.int_hold && !int_clear && regulating |=> $stable(integ))
    else $error("integral moved while held");

  no_reverse_a: // R16
    assert property (cfg.reverse_prohibit |-> g_lim >= 0)
    else $error("negative output with reverse prohibited");

  deriv_off_a: // R19
    assert property (cfg.derivative_time == 16'h0000 |-> d_term == '0)
    else $error("derivative active at zero time");

  fault_stop_a: // R21
    assert property (fault_s |-> (stop_req && fault_contact) and
                     (tick |=> freq_out == 16'h0000))
    else $error("fault did not stop drive");

  alarm_run_a: // R20
    assert property (lstate == PIDREG_LS_OK && loss_hit &&
                     cfg.loss_detect_select == `PIDREG_LOSS_ALARM |=> alarm_run_s)
    else $error("alarm missing or drive stopped");

  direct_out_a: // R1
    assert property (tick && regulating && direct_mode && !fault_contact && !loss_hit &&
                     lstate == PIDREG_LS_OK |=> freq_out == 16'($past(next_out)))
    else $error("direct output not applied");

endmodule // pidreg_top

`default_nettype wire

// ==== pidreg_defs.svh ====
// offsets, field positions, codes, reset values and timing counts of the pid regulator
// assumes values are signed 0.01 % steps of the maximum output frequency
`ifndef PIDREG_DEFS_SVH
`define PIDREG_DEFS_SVH

// serial registers
`define PIDREG_REG_TARGET   16'h0006
`define PIDREG_REG_SRCSEL   16'h000F
`define PIDREG_SRCSEL_TGT   1
`define PIDREG_RST_TARGET   16'h0000
`define PIDREG_RST_SRCSEL   16'h0000

// mode selector codes
`define PIDREG_MODE_OFF     3'h0
`define PIDREG_MODE_1       3'h1
`define PIDREG_MODE_2       3'h2
`define PIDREG_MODE_3       3'h3
`define PIDREG_MODE_4       3'h4

// input function codes
`define PIDREG_AIN_FB       8'h0B
`define PIDREG_AIN_TGT      8'h0C
`define PIDREG_PULSE_FB     2'h1
`define PIDREG_PULSE_TGT    2'h2
`define PIDREG_LOSS_ALARM   2'h1
`define PIDREG_LOSS_FAULT   2'h2

// scaling
`define PIDREG_GAIN_SHIFT   8
`define PIDREG_OFS_SCALE    38'sh00_0000_000A
`define PIDREG_SAT          16'hFFFF
`define PIDREG_OUT_MAX      16'h7FFF
`define PIDREG_RAMP_NUM     16'h0064

// timing
`define PIDREG_CLK_MHZ      40
`define PIDREG_SAMPLE_US    1000
`define PIDREG_SAMPLE_CYC   (`PIDREG_SAMPLE_US * `PIDREG_CLK_MHZ)

`endif

// ==== pidreg_pkg.sv ====
// types shared by the pid regulator files
// assumes pidreg_defs.svh holds the numbers
package pidreg_pkg;

  typedef logic signed [19:0] pidreg_val_t;

  typedef struct packed {
    logic [2:0]         pid_mode_select;
    logic [15:0]        proportional_gain;
    logic [15:0]        integral_time;
    logic [15:0]        integral_limit;
    logic [15:0]        derivative_time;
    logic [15:0]        output_limit;
    logic signed [15:0] output_offset;
    logic [3:0]         output_filter_time;
    logic               output_polarity;
    logic [15:0]        output_gain;
    logic               negative_reverse_select;
    logic [1:0]         loss_detect_select;
    logic [15:0]        loss_detect_level;
    logic [15:0]        loss_detect_time;
    logic [15:0]        target_ramp_time;
    logic               reverse_prohibit;
    logic [7:0]         analog_in2_function;
    logic [1:0]         pulse_input_function;
  } pidreg_cfg_s;

  typedef struct packed {
    logic pid_disable;
    logic int_reset;
    logic int_hold;
    logic soft_start;
  } pidreg_di_s;

  typedef enum logic [2:0] {
    PIDREG_LS_OK    = 3'b001,
    PIDREG_LS_ALARM = 3'b010,
    PIDREG_LS_FAULT = 3'b100
  } pidreg_loss_e;

endpackage

// ==== pidreg_ramp.sv ====
// target ramp of the pid regulator, one step per sample tick
// assumes tick is a one-cycle pulse from the same clock
`timescale 1ns/100ps
`default_nettype none
`include "pidreg_defs.svh"

module pidreg_ramp import pidreg_pkg::*; (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // control
  input  wire logic        tick,
  input  wire logic        bypass,
  input  wire logic [15:0] ramp_time,
  // values
  input  wire pidreg_val_t target,
  output var  pidreg_val_t ramped
);

  pidreg_val_t step;
  pidreg_val_t diff;

  // full scale over ramp_time tenths of a second at one sample per ms
  always_comb begin
    step = 20'h0_0000;
    if (ramp_time != 16'h0000) begin
      step = pidreg_val_t'(`PIDREG_RAMP_NUM / ramp_time);
    end
    if (step == 20'h0_0000) begin
      step = 20'h0_0001;
    end
    diff = target - ramped;
  end

  // R17 ramped target
  // R18 soft start bypass
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ramped <= '0;
    end else if (tick) begin
      if (bypass || ramp_time == 16'h0000) begin
        ramped <= target;
      end else if (diff > step) begin
        ramped <= ramped + step;
      end else if (diff < -step) begin
        ramped <= ramped - step;
      end else begin
        ramped <= target;
      end
    end
  end

  ramp_bypass_a: // R18
    assert property (@(posedge core_clk) disable iff (!rst_n)
      tick && bypass |=> ramped == $past(target))
    else $error("ramp not bypassed");

endmodule // pidreg_ramp

`default_nettype wire

// ==== pidreg_sensor_model.sv ====
// sensor model: analog input 2 terminal and pulse train feeding the regulator
// assumes the bench requests levels on core_clk
`timescale 1ns/100ps
`default_nettype none

module pidreg_sensor_model (
  // clock
  input  wire logic               core_clk,
  // requested levels
  input  wire logic signed [15:0] ain_set,
  input  wire logic signed [15:0] pulse_set,
  // sensor outputs
  output var  logic signed [15:0] analog_in2_terminal,
  output var  logic signed [15:0] pulse_in
);
  // sensors follow the request one cycle late
  always_ff @(posedge core_clk) begin
    analog_in2_terminal <= ain_set;
    pulse_in            <= pulse_set;
  end
endmodule // pidreg_sensor_model

`default_nettype wire

// ==== testbench.sv ====
// self-checking bench of the pid regulator top
// assumes the sensor model file and a sample period cut to 8 cycles
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import pidreg_pkg::*;
  localparam int SC = 8;
  logic               core_clk, rst_n, run, reset_cmd, reg_wr, reg_rd;
  logic               reverse_dir, pid_active, feedback_lost_alarm, fault_contact, stop_req;
  logic [15:0]        reg_addr, reg_wdata, reg_rdata;
  logic signed [15:0] freq_ref, ain_set, pulse_set, analog_in2_terminal, pulse_in, freq_out;
  pidreg_cfg_s        cfg, nc;
  pidreg_di_s         di_pins, nd;
  int                 num_errors, comparisons, t, f, d;

  pidreg_top #(.SAMPLE_CYCLES(SC)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .cfg(cfg), .di_pins(di_pins),
    .analog_in2_terminal(analog_in2_terminal), .pulse_in(pulse_in), .freq_ref(freq_ref),
    .run(run), .reset_cmd(reset_cmd), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .freq_out(freq_out),
    .reverse_dir(reverse_dir), .pid_active(pid_active),
    .feedback_lost_alarm(feedback_lost_alarm), .fault_contact(fault_contact),
    .stop_req(stop_req)
  );

  pidreg_sensor_model sens (
    .core_clk(core_clk), .ain_set(ain_set), .pulse_set(pulse_set),
    .analog_in2_terminal(analog_in2_terminal), .pulse_in(pulse_in)
  );

  task automatic give_verdict();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk_val(logic [15:0] got, logic [15:0] exp, string m);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk_bit(logic got, logic exp, string m);
    chk_val({15'h0000, got}, {15'h0000, exp}, m);
  endtask

  // proportional-only loop: error times gain g/256, plus an added term a
  function automatic logic [15:0] exp_out(int tg, int fb, int g, int a);
    return 16'((tg - fb) * g / 256 + a);
  endfunction

  task automatic reg_write(logic [15:0] a, logic [15:0] w);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= w;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic reg_read(logic [15:0] a, logic [15:0] e, string m);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    chk_val(reg_rdata, e, m);
  endtask

  // apply settings and levels, then let n samples pass
  task automatic go(int n, logic signed [15:0] fr, logic signed [15:0] a, logic signed [15:0] p);
    @(posedge core_clk);
    cfg       <= nc;
    di_pins   <= nd;
    freq_ref  <= fr;
    ain_set   <= a;
    pulse_set <= p;
    repeat (n * SC) @(posedge core_clk);
    #1;
  endtask

  // gain 1, no integral, no derivative, mode 1, feedback from analog input
  task automatic base();
    nc = '0;
    nc.pid_mode_select     = 3'h1;
    nc.proportional_gain   = 16'h0100;
    nc.integral_limit      = 16'h7FFF;
    nc.output_limit        = 16'h2710;
    nc.output_gain         = 16'h0100;
    nc.analog_in2_function = 8'h0B;
    nd = '0;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  initial begin
    repeat (100000) @(posedge core_clk);
    num_errors++;
    give_verdict();
  end

  initial begin
    {rst_n, run, reset_cmd, reg_wr, reg_rd} = '0;
    {reg_addr, reg_wdata, freq_ref, ain_set, pulse_set} = '0;
    base();
    cfg = nc;
    di_pins = nd;
    num_errors = 0;
    comparisons = 0;
    void'($urandom(15382));
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    run   <= 1'b1;
    reg_read(16'h0006, 16'h0000, "target reset");
    reg_read(16'h000F, 16'h0000, "source reset");
    reg_write(16'h0007, 16'hFFFF);
    reg_read(16'h0007, 16'h0000, "unmapped read");
    t = 1501 + $urandom_range(1500);
    f = $urandom_range(1000);
    d = t - f;
    reg_write(16'h0006, t[15:0]);
    reg_read(16'h0006, t[15:0], "target readback");
    nc.pid_mode_select = 3'h0;
    go(4, t[15:0], 0, 0);
    chk_val(freq_out, t[15:0], "mode 0 pass");
    chk_bit(pid_active, 1'b0, "mode 0 idle");
    reg_write(16'h000F, 16'h0002);
    for (int m = 1; m <= 4; m++) begin
      base();
      nc.pid_mode_select = m[2:0];
      go(4, 16'sh07D0, f[15:0], 0);
      chk_val(freq_out, exp_out(t, f, 256, (m < 3) ? 0 : 2000), "mode output");
      chk_bit(pid_active, 1'b1, "mode active");
    end
    nd.pid_disable = 1'b1;
    go(4, 16'sh07D0, f[15:0], 0);
    chk_val(freq_out, 16'h07D0, "disable pass");
    chk_bit(pid_active, 1'b0, "disable idle");
    base();
    nc.output_limit = 16'h01F4;
    go(4, 0, f[15:0], 0);
    chk_val(freq_out, 16'h01F4, "output limit");
    base();
    nc.output_offset = 16'sh0005;
    go(4, 0, f[15:0], 0);
    chk_val(freq_out, exp_out(t, f, 256, 50), "offset");
    base();
    nc.output_gain = 16'h0200;
    go(4, 0, f[15:0], 0);
    chk_val(freq_out, exp_out(t, f, 512, 0), "gain");
    base();
    nc.output_polarity = 1'b1;
    nc.negative_reverse_select = 1'b1;
    go(4, 0, f[15:0], 0);
    chk_val(freq_out, 16'(-d), "inverted");
    chk_bit(reverse_dir, 1'b1, "reverse on");
    nc.reverse_prohibit = 1'b1;
    go(4, 0, f[15:0], 0);
    chk_val(freq_out, 16'h0000, "reverse blocked");
    chk_bit(reverse_dir, 1'b0, "reverse off");
    base();
    nc.integral_time = 16'h0001;
    nc.integral_limit = 16'h012C;
    go(12, 0, f[15:0], 0);
    chk_val(freq_out, 16'(d + 300), "integral clamp");
    nd.int_reset = 1'b1;
    go(4, 0, f[15:0], 0);
    chk_val(freq_out, 16'(d), "integral reset");
    nd.int_reset = 1'b0;
    nd.int_hold = 1'b1;
    go(6, 0, f[15:0], 0);
    chk_val(freq_out, 16'(d), "integral hold");
    reg_write(16'h000F, 16'h0000);
    base();
    go(4, t[15:0], f[15:0], 0);
    chk_val(freq_out, 16'(d), "default target");
    nc.analog_in2_function = 8'h0C;
    nc.pulse_input_function = 2'h1;
    go(4, 0, t[15:0], f[15:0]);
    chk_val(freq_out, 16'(d), "analog target");
    nc.analog_in2_function = 8'h0B;
    nc.pulse_input_function = 2'h2;
    go(4, 0, f[15:0], t[15:0]);
    chk_val(freq_out, 16'(d), "pulse target");
    reg_write(16'h0006, 16'h0000);
    reg_write(16'h000F, 16'h0002);
    base();
    go(4, 0, 0, 0);
    nc.target_ramp_time = 16'h0001;
    go(1, 0, 0, 0);
    reg_write(16'h0006, 16'h07D0);
    go(3, 0, 0, 0);
    chk_bit(freq_out < 16'sh07D0, 1'b1, "ramp slow");
    go(25, 0, 0, 0);
    chk_val(freq_out, 16'h07D0, "ramp done");
    nd.soft_start = 1'b1;
    reg_write(16'h0006, 16'h0000);
    go(4, 0, 0, 0);
    chk_val(freq_out, 16'h0000, "ramp bypass");
    reg_write(16'h0006, 16'h07D0);
    base();
    nc.loss_detect_select = 2'h1;
    nc.loss_detect_level = 16'h03E8;
    nc.loss_detect_time = 16'h0002;
    go(6, 0, 0, 0);
    chk_bit(feedback_lost_alarm, 1'b1, "alarm raised");
    chk_bit(fault_contact, 1'b0, "alarm no fault");
    chk_val(freq_out, 16'h07D0, "alarm runs");
    go(4, 0, 16'sh05DC, 0);
    chk_bit(feedback_lost_alarm, 1'b0, "alarm cleared");
    nc.loss_detect_select = 2'h2;
    go(6, 0, 0, 0);
    chk_bit(fault_contact, 1'b1, "fault contact");
    chk_bit(stop_req, 1'b1, "fault stop");
    chk_val(freq_out, 16'h0000, "fault output");
    go(4, 0, 16'sh05DC, 0);
    @(posedge core_clk);
    reset_cmd <= 1'b1;
    @(posedge core_clk);
    reset_cmd <= 1'b0;
    go(4, 0, 16'sh05DC, 0);
    chk_bit(fault_contact, 1'b0, "fault cleared");
    chk_val(freq_out, 16'h01F4, "run resumed");
    give_verdict();
  end
endmodule // testbench

`default_nettype wire
